// *** design/sdfc_cfg.svh ***
// Constants of the serial DAC frame control: frame layout, reset code, link timing.
// Assumes a 10 MHz system clock on the host end and a host-made shift clock.
// Function
// RULE_01: Frame starts on falling edge of select
// RULE_02: Shift data in on falling clock edges
// RULE_03: Sixteenth falling edge executes the frame
// RULE_04: Host holds select low sixteen edges
// RULE_05: Select high at least 33 ns between frames
// RULE_06: Host parks select low between frames; the design does so only after a full frame, not after reset or abort
// RULE_07: Shift clock never faster than 30 MHz
// RULE_08: First two bits ignored, next two mode
// RULE_09: Last twelve bits load DAC register; the design loads them only on normal-mode frames
// RULE_10: Most significant bit is sent first
// RULE_11: Early select rise discards the frame
// RULE_12: Power-up clears DAC register to zero
// RULE_13: Mode bits decode to four operating modes
// RULE_14: Power-down disconnects amplifier, switches load, stops bias
// RULE_15: Power-down keeps stored DAC code
// RULE_16: Byte hosts keep select low across bytes
// RULE_17: Edges after sixteenth are ignored until reselect
`ifndef SDFC_CFG_SVH
`define SDFC_CFG_SVH

`define SDFC_FRAME_BITS 16
`define SDFC_DATA_BITS 12
`define SDFC_MODE_HI 13
`define SDFC_MODE_LO 12
`define SDFC_CODE_RESET 12'h000
`define SDFC_CLK_MHZ 10
`define SDFC_SCLK_MAX_MHZ 30
`define SDFC_SYNC_HIGH_NS 33
`define SDFC_SYNC_HIGH_CYC_RAW ((`SDFC_SYNC_HIGH_NS * `SDFC_CLK_MHZ + 999) / 1000)
`define SDFC_SYNC_HIGH_CYC ((`SDFC_SYNC_HIGH_CYC_RAW < 1) ? 1 : `SDFC_SYNC_HIGH_CYC_RAW)

`endif

// *** design/sdfc_pkg.sv ***
// Types of the serial DAC frame control: modes, host states and state records.
// Assumes sdfc_cfg.svh is on the include path.
`include "sdfc_cfg.svh"

package sdfc_pkg;

    typedef enum logic [1:0] {
        SDFC_NORMAL,
        SDFC_PD_1K,
        SDFC_PD_100K,
        SDFC_PD_FLOAT
    } sdfc_mode_t;

    typedef enum logic [1:0] {
        SDFC_PARK,
        SDFC_RAISE,
        SDFC_SHIFT
    } sdfc_hstate_t;

    // Link-side frame capture, cleared whenever the select is high
    typedef struct packed {
        logic [3:0] bitCnt;
        logic [`SDFC_FRAME_BITS-1:0] shift;
        logic done;
    } sdfc_frame_t;

    // Link-side executed word, survives select changes
    typedef struct packed {
        logic [`SDFC_FRAME_BITS-1:0] word;
        logic tog;
    } sdfc_held_t;

    // Device system-clock side
    typedef struct packed {
        logic togMeta;
        logic togSync;
        logic togSeen;
        logic [`SDFC_DATA_BITS-1:0] code;
        sdfc_mode_t mode;
        logic upd;
    } sdfc_dev_t;

    typedef struct packed {
        sdfc_hstate_t st;
        logic [7:0] divCnt;
        logic [3:0] bitCnt;
        logic [7:0] hiCnt;
        logic [`SDFC_FRAME_BITS-1:0] shift;
        logic syncN;
        logic sclk;
        logic din;
        logic done;
    } sdfc_host_t;

endpackage

// *** design/sdfc_if.sv ***
// Three-wire write link between the host serial master and the DAC control.
// Host drives all three wires; the shift clock idles low.
`timescale 1ns/10ps

interface sdfc_if;
    logic syncN;
    logic sclk;
    logic din;

    modport host (
        output syncN,
        output sclk,
        output din
    );

    modport dev (
        input syncN,
        input sclk,
        input din
    );
endinterface // sdfc_if

// *** design/sdfc_device.sv ***
// DAC frame control, device end: captures frames on the link clock,
// hands executed words to the system clock and drives the output stage controls.
// Assumes the host keeps the link timing; sclk may stop outside frames.
`timescale 1ns/10ps
`include "sdfc_cfg.svh"

module sdfc_device
    import sdfc_pkg::*;
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Link
    sdfc_if.dev link,
    // DAC core controls
    output logic [`SDFC_DATA_BITS-1:0] dacCode,
    output sdfc_mode_t opMode,
    output logic ampToOut,
    output logic biasOn,
    output logic pull1k,
    output logic pull100k,
    output logic outFloat,
    output logic update
);

    sdfc_frame_t frm_r;
    sdfc_frame_t frm_nxt;
    sdfc_held_t held_r;
    sdfc_held_t held_nxt;
    sdfc_dev_t dev_r;
    sdfc_dev_t dev_nxt;
    logic frameRst;
    logic fire;
    logic [`SDFC_FRAME_BITS-1:0] fullWord;
    sdfc_mode_t newMode;

    // Select high clears capture at once, without a clock edge
    assign frameRst = ~rst_n | link.syncN; // RULE_01 RULE_05 RULE_11

    assign fullWord = {frm_r.shift[`SDFC_FRAME_BITS-2:0], link.din};

    always_comb begin
        frm_nxt = frm_r;
        fire = 1'b0;
        if (!frm_r.done) begin // RULE_17
            frm_nxt.shift = fullWord; // RULE_02 RULE_10
            if (frm_r.bitCnt == 4'(`SDFC_FRAME_BITS - 1)) begin
                frm_nxt.done = 1'b1;
                fire = 1'b1; // RULE_03
            end else begin
                frm_nxt.bitCnt = frm_r.bitCnt + 4'h1;
            end
        end
    end

    always_ff @(negedge link.sclk or posedge frameRst) begin
        if (frameRst) begin
            frm_r <= '0;
        end else begin
            frm_r <= frm_nxt;
        end
    end

    always_comb begin
        held_nxt = held_r;
        if (fire) begin
            held_nxt.word = fullWord; // RULE_03
            held_nxt.tog = ~held_r.tog;
        end
    end

    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            held_r <= '0;
        end else begin
            held_r <= held_nxt;
        end
    end

    // Toggle crossing; the word is stable until another full frame arrives
    assign newMode = sdfc_mode_t'(held_r.word[`SDFC_MODE_HI:`SDFC_MODE_LO]); // RULE_08 RULE_13

    always_comb begin
        dev_nxt = dev_r;
        dev_nxt.togMeta = held_r.tog;
        dev_nxt.togSync = dev_r.togMeta;
        dev_nxt.togSeen = dev_r.togSync;
        dev_nxt.upd = 1'b0;
        if (dev_r.togSync != dev_r.togSeen) begin
            dev_nxt.mode = newMode; // RULE_13
            dev_nxt.upd = 1'b1;
            if (newMode == SDFC_NORMAL) begin
                dev_nxt.code = held_r.word[`SDFC_DATA_BITS-1:0]; // RULE_09
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dev_r.togMeta <= 1'b0;
            dev_r.togSync <= 1'b0;
            dev_r.togSeen <= 1'b0;
            dev_r.code <= `SDFC_CODE_RESET; // RULE_12
            dev_r.mode <= SDFC_NORMAL;
            dev_r.upd <= 1'b0;
        end else begin
            dev_r <= dev_nxt; // RULE_15
        end
    end

    assign dacCode = dev_r.code;
    assign opMode = dev_r.mode;
    assign update = dev_r.upd;

    // Output stage: amplifier only in normal mode, else the chosen load or a floating output
    assign ampToOut = (dev_r.mode == SDFC_NORMAL); // RULE_14
    assign biasOn = (dev_r.mode == SDFC_NORMAL); // RULE_14
    assign pull1k = (dev_r.mode == SDFC_PD_1K); // RULE_14
    assign pull100k = (dev_r.mode == SDFC_PD_100K); // RULE_14
    assign outFloat = (dev_r.mode == SDFC_PD_FLOAT); // RULE_14

endmodule // sdfc_device

// *** design/sdfc_host.sv ***
// DAC frame control, host end: serial master that sends one 16-bit frame
// per accepted command, making the shift clock from clk by a divider.
// Assumes clk at 10 MHz; commands come from logic on clk.
`timescale 1ns/10ps
`include "sdfc_cfg.svh"

module sdfc_host
    import sdfc_pkg::*;
#(
    parameter int SCLK_DIV = 1
)
(
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire sdfc_mode_t cmdMode,
    input wire logic [`SDFC_DATA_BITS-1:0] cmdCode,
    input wire logic abortReq,
    // Status
    output logic busy,
    output logic frameDone,
    // Link
    sdfc_if.host link
);

    localparam int HIGH_CYC = `SDFC_SYNC_HIGH_CYC;

    if (SCLK_DIV < 1 || SCLK_DIV > 255 ||
        `SDFC_CLK_MHZ > `SDFC_SCLK_MAX_MHZ * 2 * SCLK_DIV) begin : gBadDiv
        $error("SCLK_DIV out of range"); // RULE_07
    end
    if (HIGH_CYC > 256) begin : gBadHigh
        $error("Select high time too long");
    end

    sdfc_host_t h_r;
    sdfc_host_t h_nxt;

    assign cmdReady = (h_r.st == SDFC_PARK);

    always_comb begin
        h_nxt = h_r;
        h_nxt.done = 1'b0;
        unique case (h_r.st)
            SDFC_PARK: begin
                if (cmdValid) begin
                    h_nxt.shift = {2'b00, 2'(cmdMode), cmdCode}; // RULE_08 RULE_10
                    h_nxt.syncN = 1'b1; // RULE_05
                    h_nxt.hiCnt = 8'(HIGH_CYC - 1);
                    h_nxt.st = SDFC_RAISE;
                end
            end
            SDFC_RAISE: begin
                if (h_r.hiCnt == 8'h00) begin
                    h_nxt.syncN = 1'b0; // RULE_01
                    h_nxt.divCnt = 8'h00;
                    h_nxt.bitCnt = 4'h0;
                    h_nxt.st = SDFC_SHIFT;
                end else begin
                    h_nxt.hiCnt = h_r.hiCnt - 8'h01;
                end
            end
            SDFC_SHIFT: begin
                if (abortReq) begin
                    h_nxt.syncN = 1'b1;
                    h_nxt.sclk = 1'b0;
                    h_nxt.st = SDFC_PARK;
                end else if (h_r.divCnt == 8'(SCLK_DIV - 1)) begin
                    h_nxt.divCnt = 8'h00;
                    if (!h_r.sclk) begin
                        h_nxt.sclk = 1'b1;
                        h_nxt.din = h_r.shift[`SDFC_FRAME_BITS-1]; // RULE_10
                    end else begin
                        h_nxt.sclk = 1'b0;
                        h_nxt.shift = {h_r.shift[`SDFC_FRAME_BITS-2:0], 1'b0};
                        if (h_r.bitCnt == 4'(`SDFC_FRAME_BITS - 1)) begin
                            h_nxt.done = 1'b1; // RULE_04 RULE_16
                            h_nxt.st = SDFC_PARK; // RULE_06
                        end else begin
                            h_nxt.bitCnt = h_r.bitCnt + 4'h1;
                        end
                    end
                end else begin
                    h_nxt.divCnt = h_r.divCnt + 8'h01;
                end
            end
            // Unused state code falls back to idle
            default: begin
                h_nxt.st = SDFC_PARK;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            h_r.st <= SDFC_PARK;
            h_r.divCnt <= 8'h00;
            h_r.bitCnt <= 4'h0;
            h_r.hiCnt <= 8'h00;
            h_r.shift <= 16'h0000;
            h_r.syncN <= 1'b1;
            h_r.sclk <= 1'b0;
            h_r.din <= 1'b0;
            h_r.done <= 1'b0;
        end else begin
            h_r <= h_nxt;
        end
    end

    assign busy = (h_r.st != SDFC_PARK);
    assign frameDone = h_r.done;
    assign link.syncN = h_r.syncN;
    assign link.sclk = h_r.sclk;
    assign link.din = h_r.din;

endmodule // sdfc_host

// *** verification/sdfc_link_chk.sv ***
// Checker of the three-wire link joining the host end to the device end.
// Assumes the link wires are host flops on clk and SCLK_DIV is 1.
`timescale 1ns/10ps

module sdfc_link_chk (
    // System
    input wire logic clk,
    input wire logic rst_n,
    // Link
    input wire logic syncN,
    input wire logic sclk,
    input wire logic din
);
    logic sclkQ;
    logic [4:0] edgeCnt;

    // Falling shift-clock edges seen in the current frame
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclkQ <= 1'h0;
            edgeCnt <= 5'h00;
        end else begin
            sclkQ <= sclk;
            if (syncN) begin
                edgeCnt <= 5'h00;
            end else if (sclkQ && !sclk) begin
                edgeCnt <= edgeCnt + 5'h01;
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_lead;
        $fell(syncN) ##1 sclk;
    endsequence

    property p_idle; syncN && $past(syncN) |-> !sclk; endproperty
    property p_start; $fell(syncN) |=> sclk || syncN; endproperty
    property p_frame; s_lead |=> !sclk || syncN; endproperty
    property p_half; $rose(sclk) |=> !sclk; endproperty
    property p_hold; $fell(sclk) |-> $stable(din); endproperty
    property p_max16; $rose(sclk) |-> edgeCnt < 5'h10; endproperty
    property p_count; edgeCnt <= 5'h10; endproperty
    property p_fresh; $fell(syncN) |-> edgeCnt == 5'h00; endproperty

    a_idle: assert property (p_idle) else $error("clock high outside frame");
    a_start: assert property (p_start) else $error("no clock after select");
    a_frame: assert property (p_frame) else $error("first bit not sampled");
    a_half: assert property (p_half) else $error("clock high too long");
    a_hold: assert property (p_hold) else $error("data moved at sample");
    a_max16: assert property (p_max16) else $error("clock after last bit");
    a_count: assert property (p_count) else $error("frame too long");
    a_fresh: assert property (p_fresh) else $error("frame without gap");
endmodule // sdfc_link_chk

// *** verification/tb_serial_dac_frame_control.sv ***
// Self-checking bench: the host end drives the device end over the link.
// Assumes a 10 MHz clk and SCLK_DIV of 1.
`timescale 1ns/10ps

module tb_serial_dac_frame_control
    import sdfc_pkg::*;
;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic cmdValid = 1'h0;
    logic abortReq = 1'h0;
    sdfc_mode_t cmdMode = SDFC_NORMAL;
    logic [11:0] cmdCode = 12'h000;
    logic cmdReady, busy, frameDone, ampToOut, biasOn, pull1k, pull100k, outFloat, update;
    logic [11:0] dacCode;
    sdfc_mode_t opMode;
    logic [15:0] seenWord;
    logic [11:0] expCode = 12'h000;
    int updCnt = 0;
    int failures = 0;
    int checked = 0;

    sdfc_if link ();
    sdfc_host #(.SCLK_DIV(1)) sdfc_host_inst (.clk(clk), .rst_n(rst_n), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdMode(cmdMode), .cmdCode(cmdCode), .abortReq(abortReq),
        .busy(busy), .frameDone(frameDone), .link(link));
    sdfc_device sdfc_device_inst (.clk(clk), .rst_n(rst_n), .link(link), .dacCode(dacCode),
        .opMode(opMode), .ampToOut(ampToOut), .biasOn(biasOn), .pull1k(pull1k),
        .pull100k(pull100k), .outFloat(outFloat), .update(update));
    sdfc_link_chk sdfc_link_chk_inst (.clk(clk), .rst_n(rst_n), .syncN(link.syncN),
        .sclk(link.sclk), .din(link.din));

    initial begin
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        updCnt <= updCnt + int'(update);
    end
    // Word as the device samples it
    always @(negedge link.sclk) begin
        if (!link.syncN) begin
            seenWord <= {seenWord[14:0], link.din};
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic check_outputs(input sdfc_mode_t m);
        logic [4:0] stage;
        stage = (m == SDFC_NORMAL) ? 5'h18 : 5'h01 << (3 - int'(m));
        check(16'(opMode), 16'(m));
        check(16'(dacCode), 16'(expCode));
        check(16'({ampToOut, biasOn, pull1k, pull100k, outFloat}), 16'(stage));
    endtask

    task automatic send(input sdfc_mode_t m, input logic [11:0] c);
        int n;
        n = updCnt;
        check(16'(cmdReady), 16'h0001);
        cmdValid = 1'h1;
        cmdMode = m;
        cmdCode = c;
        @(posedge clk) #1;
        cmdValid = 1'h0;
        for (int i = 0; i < 60 && frameDone !== 1'h1; i++) @(posedge clk) #1;
        check(16'(frameDone), 16'h0001);
        check(16'(link.syncN), 16'h0000);
        check(seenWord, {2'h0, m, c});
        for (int i = 0; i < 8 && updCnt == n; i++) @(posedge clk) #1;
        check(16'(updCnt - n), 16'h0001);
        if (m == SDFC_NORMAL) begin
            expCode = c;
        end
        check(16'(dacCode), 16'(expCode));
        check_outputs(m);
    endtask

    task automatic abort_frame(input sdfc_mode_t m);
        int n;
        n = updCnt;
        cmdValid = 1'h1;
        cmdMode = SDFC_PD_FLOAT;
        cmdCode = 12'h123;
        @(posedge clk) #1;
        cmdValid = 1'h0;
        repeat (20) @(posedge clk);
        #1 abortReq = 1'h1;
        @(posedge clk) #1;
        abortReq = 1'h0;
        repeat (10) @(posedge clk);
        #1 check(16'(busy), 16'h0000);
        check(16'(link.syncN), 16'h0001);
        check(16'(updCnt - n), 16'h0000);
        check_outputs(m);
    endtask

    task automatic final_report();
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    initial begin
        @(posedge clk) #1;
        check(16'(link.syncN), 16'h0001);
        check(16'(update), 16'h0000);
        check_outputs(SDFC_NORMAL);
        @(posedge clk) #1 rst_n = 1'h1;
        send(SDFC_NORMAL, 12'hA5C);
        for (int k = 1; k < 4; k++) begin
            send(sdfc_mode_t'(k), 12'h3F0);
        end
        send(SDFC_NORMAL, 12'hFFF);
        abort_frame(SDFC_NORMAL);
        send(SDFC_PD_1K, 12'h001);
        send(SDFC_NORMAL, 12'h000);
        final_report();
    end

    initial begin
        #100000;
        failures++;
        final_report();
    end
endmodule // tb_serial_dac_frame_control
